/* File: tcg_pkg.sv */
// Constants shared by the timer counter group host access block.
// Assumes a single 100 MHz clock domain and asynchronous host pins.
package tcg_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int W  = 16;
  localparam int B  = 8;
  localparam int NG = 5;
  localparam int NA = 2;

  // ----------------------------------------------------------------
  // Data pointer codes
  // ----------------------------------------------------------------
  localparam logic [2:0] G_FIRST = 3'h1;
  localparam logic [2:0] G_LAST  = 3'h5;
  localparam logic [2:0] G_CTRL  = 3'h7;
  localparam logic [2:0] G_STEP  = 3'h1;
  localparam logic [1:0] E_MODE  = 2'h0;
  localparam logic [1:0] E_LOAD  = 2'h1;
  localparam logic [1:0] E_HOLD  = 2'h2;
  localparam logic [1:0] E_HOLDC = 2'h3;
  localparam logic [1:0] E_ALM1  = 2'h0;
  localparam logic [1:0] E_ALM2  = 2'h1;
  localparam logic [1:0] E_MMR   = 2'h2;
  localparam logic [1:0] E_STAT  = 2'h3;
  localparam logic [1:0] E_STEP  = 2'h1;

  // ----------------------------------------------------------------
  // Master mode and counter mode bits
  // ----------------------------------------------------------------
  localparam int MM_CMP1     = 2;
  localparam int MM_CMP2     = 3;
  localparam int MM_BUS16    = 13;
  localparam int MM_SEQDIS   = 14;
  localparam int MM_CMD_BASE = 8;
  localparam int CM_POL      = 2;
  localparam int CM_SRC_HOLD = 6;
  localparam logic [W-1:0] REG_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CMD_LDP    = 3'h0;
  localparam logic [2:0] CMD_SAVE   = 3'h5;
  localparam logic [4:0] CMD_SETB   = 5'h1d;
  localparam logic [4:0] CMD_CLRB   = 5'h1c;
  localparam logic [2:0] CMD_BIT_LO = 3'h4;
  localparam logic [2:0] CMD_BIT_HI = 3'h6;

  // ----------------------------------------------------------------
  // Synchronised pin vector layout
  // ----------------------------------------------------------------
  localparam int F_SRC = 0;
  localparam int F_DAT = NG;
  localparam int F_WR  = NG + W;
  localparam int F_RD  = F_WR + 1;
  localparam int F_CD  = F_WR + 2;
  localparam int F_CS  = F_WR + 3;
  localparam int SW    = F_WR + 4;
  localparam logic [3:0] STB_RST = 4'hb;
endpackage

/* File: tcg_grp_if.sv */
// Link between the host access logic and one counter group.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface tcg_grp_if;
  import tcg_pkg::*;
  logic [W-1:0] load;
  logic [W-1:0] hold;
  logic [W-1:0] mode;
  logic [W-1:0] alarm;
  logic         cmp_en;
  logic         tick;
  logic [W-1:0] cnt;
  logic         out;
  modport ctl (output load, hold, mode, alarm, cmp_en, tick, input cnt, out);
  modport grp (input load, hold, mode, alarm, cmp_en, tick, output cnt, out);
endinterface
`default_nettype wire

/* File: tcg_counter.sv */
// One counter group: down counter, terminal count, comparator, output.
// Assumes tick is a one-cycle pulse on the same clock.
`timescale 1ns/100ps
`default_nettype none
module tcg_counter
  import tcg_pkg::*;
#(
  parameter int W_CNT     = W,
  parameter bit HAS_ALARM = 1'b0
) (
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_ce,
  tcg_grp_if.grp    g
);
  localparam logic [W_CNT-1:0] ONE = {{(W_CNT-1){1'b0}}, 1'b1};

  if (W_CNT != W) begin : g_chk
    $error("tcg_counter width must match the group link");
  end

  logic [W_CNT-1:0] cnt_q, cnt_d;
  logic             tc_q, tc_d;
  logic             out_q, out_d;
  logic             cmp;

  // ----------------------------------------------------------------
  // Counting and output select
  // ----------------------------------------------------------------
  always_comb begin
    cnt_d = cnt_q;
    tc_d  = tc_q;
    if (g.tick) begin
      tc_d = (cnt_q == ONE);
      if (cnt_q == ONE) begin
        cnt_d = g.mode[CM_SRC_HOLD] ? g.hold : g.load;
      end else begin
        cnt_d = cnt_q - ONE;
      end
    end
    cmp = HAS_ALARM && (cnt_q == g.alarm);
    if (HAS_ALARM && g.cmp_en) begin
      out_d = cmp ^ g.mode[CM_POL];
    end else begin
      out_d = tc_q ^ g.mode[CM_POL];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q <= REG_RST;
      tc_q  <= 1'b0;
      out_q <= 1'b0;
    end else if (i_ce) begin
      cnt_q <= cnt_d;
      tc_q  <= tc_d;
      out_q <= out_d;
    end
  end

  assign g.cnt = cnt_q;
  assign g.out = out_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  tc_reload_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && g.tick && cnt_q == ONE
    |=> tc_q && (cnt_q == $past(g.mode[CM_SRC_HOLD] ? g.hold : g.load)))
    else $error("terminal count reload missed");
  count_step_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && g.tick && cnt_q != ONE |=> cnt_q == $past(cnt_q) - ONE && !tc_q)
    else $error("counter step wrong");
  cmp_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && HAS_ALARM && g.cmp_en && cnt_q == g.alarm && !g.mode[CM_POL] |=> out_q)
    else $error("comparator output not true on match");
  freeze_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !i_ce |=> $stable(cnt_q) && $stable(out_q))
    else $error("counter moved while frozen");
endmodule // tcg_counter
`default_nettype wire

/* File: tcg_host_access.sv */
// Host access logic and register storage for five counter groups.
// Assumes asynchronous host strobes and count inputs on pins.
//
// Behaviour
// - Five groups: counter, reload, capture, mode registers
// - Counter itself never readable or writable directly
// - Terminal count reloads from reload or capture
// - Terminal count marks would-be zero interval
// - All-zero reload keeps accumulation intact
// - Save command copies counter into capture register
// - Comparator true while count equals alarm
// - Enabled comparator drives the output pin
// - Comparator polarity follows output control field
// - Two comparators enabled by separate master bits
// - Strobes ignored unless chip select low
// - Data port reads or writes pointed register
// - Control port reads status, writes command
// - Write captured on rising write strobe
// - Pointer load sets byte pointer to one
// - Auto sequencing unless disable bit set
// - Status read shows live output state
// - Only listed registers accept data writes
// - Back-to-back accesses need no deselect
// - Byte pointer toggles 8-bit, stays set 16-bit
// - Pointer update then prefetch into latch
// - Element cycle 00,01,10 then next group
`timescale 1ns/100ps
`default_nettype none
module tcg_host_access
  import tcg_pkg::*;
(
  input  wire logic          i_clk,
  input  wire logic          i_resetn,
  input  wire logic          i_ce,
  input  wire logic          i_cs_n,
  input  wire logic          i_cd,
  input  wire logic          i_rd_n,
  input  wire logic          i_wr_n,
  input  wire logic [W-1:0]  i_data,
  input  wire logic [NG-1:0] i_count_src,
  output logic      [W-1:0]  o_data,
  output logic               o_data_oe_lo,
  output logic               o_data_oe_hi,
  output logic      [NG-1:0] o_out
);
  localparam logic [SW-1:0] SYNC_RST = {STB_RST, {(SW-4){1'b0}}};

  // ----------------------------------------------------------------
  // Pin synchronisers and filter
  // ----------------------------------------------------------------
  logic [SW-1:0] s1_q, s2_q, s3_q, f_q, fp_q, f_d;

  always_comb begin
    f_d = ((s2_q ~^ s3_q) & s2_q) | ((s2_q ^ s3_q) & f_q);
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
      s3_q <= SYNC_RST;
      f_q  <= SYNC_RST;
      fp_q <= SYNC_RST;
    end else if (i_ce) begin
      s1_q <= {i_cs_n, i_cd, i_rd_n, i_wr_n, i_data, i_count_src};
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q  <= f_d;
      fp_q <= f_q;
    end
  end

  // ----------------------------------------------------------------
  // Strobe decode
  // ----------------------------------------------------------------
  logic         wr_edge, rd_edge, data_wr, cmd_wr, data_rd_end, acc;
  logic         reading, rd_stat;
  logic [W-1:0] dat;
  logic [NG-1:0] ticks;

  assign wr_edge     = !fp_q[F_CS] && !fp_q[F_WR] && f_q[F_WR];
  assign rd_edge     = !fp_q[F_CS] && !fp_q[F_RD] && f_q[F_RD];
  assign dat         = fp_q[F_DAT +: W];
  assign data_wr     = wr_edge && !fp_q[F_CD];
  assign cmd_wr      = wr_edge && fp_q[F_CD];
  assign data_rd_end = rd_edge && !fp_q[F_CD];
  assign acc         = data_wr || data_rd_end;
  assign reading     = !f_q[F_CS] && !f_q[F_RD] && f_q[F_WR];
  assign rd_stat     = reading && f_q[F_CD];
  assign ticks       = f_q[F_SRC +: NG] & ~fp_q[F_SRC +: NG];

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [W-1:0] load_q [NG], load_d [NG];
  logic [W-1:0] hold_q [NG], hold_d [NG];
  logic [W-1:0] mode_q [NG], mode_d [NG];
  logic [W-1:0] alarm_q [NA], alarm_d [NA];
  logic [W-1:0] mm_q, mm_d, pf_q, pf_d, o_data_q, o_data_d;
  logic [2:0]   grp_q, grp_d, gi, gnext;
  logic [1:0]   elem_q, elem_d;
  logic         bp_q, bp_d, pf_pend_q, pf_pend_d;
  logic         oe_lo_q, oe_lo_d, oe_hi_q, oe_hi_d;
  logic [W-1:0] rdv, nw, stat;
  logic [W-1:0] cnt_vec [NG];
  logic [NG-1:0] out_vec;
  logic         grp_ok, bus16, full;
  logic [B-1:0] cmd;

  always_comb begin
    load_d    = load_q;
    hold_d    = hold_q;
    mode_d    = mode_q;
    alarm_d   = alarm_q;
    mm_d      = mm_q;
    grp_d     = grp_q;
    elem_d    = elem_q;
    bp_d      = bp_q;
    pf_d      = pf_q;
    pf_pend_d = pf_pend_q;
    cmd       = dat[B-1:0];
    bus16     = mm_q[MM_BUS16];
    full      = bus16 || !bp_q;
    grp_ok    = (grp_q >= G_FIRST) && (grp_q <= G_LAST);
    gi        = grp_q - G_STEP;
    gnext     = (grp_q == G_LAST) ? G_FIRST : grp_q + G_STEP;
    stat      = W'({out_vec, bp_q});
    // Read path: the counter itself is not on it
    rdv = REG_RST;
    if (grp_ok) begin
      case (elem_q)
        E_MODE:  rdv = mode_q[gi];
        E_LOAD:  rdv = load_q[gi];
        default: rdv = hold_q[gi];
      endcase
    end else if (grp_q == G_CTRL) begin
      case (elem_q)
        E_ALM1:  rdv = alarm_q[0];
        E_ALM2:  rdv = alarm_q[1];
        E_MMR:   rdv = mm_q;
        default: rdv = stat;
      endcase
    end
    // Merge of one byte or a whole word into the pointed register
    if (bus16) begin
      nw = dat;
    end else if (bp_q) begin
      nw = {rdv[W-1:B], dat[B-1:0]};
    end else begin
      nw = {dat[B-1:0], rdv[B-1:0]};
    end
    if (pf_pend_q) begin
      pf_d      = rdv;
      pf_pend_d = 1'b0;
    end
    if (data_wr) begin
      if (grp_ok) begin
        case (elem_q)
          E_MODE:  mode_d[gi] = nw;
          E_LOAD:  load_d[gi] = nw;
          default: hold_d[gi] = nw;
        endcase
      end else if (grp_q == G_CTRL) begin
        case (elem_q)
          E_ALM1:  alarm_d[0] = nw;
          E_ALM2:  alarm_d[1] = nw;
          E_MMR:   mm_d = nw;
          default: mm_d = mm_q;
        endcase
      end
    end
    if (acc) begin
      bp_d      = bus16 ? 1'b1 : !bp_q;
      pf_pend_d = 1'b1;
      if (full && !mm_q[MM_SEQDIS]) begin
        if (grp_ok) begin
          if (elem_q == E_HOLDC) begin
            grp_d = gnext;
          end else if (elem_q == E_HOLD) begin
            elem_d = E_MODE;
            grp_d  = gnext;
          end else begin
            elem_d = elem_q + E_STEP;
          end
        end else if (grp_q == G_CTRL && elem_q != E_STAT) begin
          elem_d = (elem_q == E_MMR) ? E_ALM1 : elem_q + E_STEP;
        end
      end
    end
    if (cmd_wr) begin
      if (cmd[7:5] == CMD_LDP) begin
        grp_d     = cmd[2:0];
        elem_d    = cmd[4:3];
        bp_d      = 1'b1;
        pf_pend_d = 1'b1;
      end else if (cmd[7:5] == CMD_SAVE) begin
        for (int i = 0; i < NG; i++) begin
          if (cmd[i]) begin
            hold_d[i] = cnt_vec[i];
          end
        end
      end else if (cmd[2:0] >= CMD_BIT_LO && cmd[2:0] <= CMD_BIT_HI) begin
        if (cmd[7:3] == CMD_SETB) begin
          mm_d[MM_CMD_BASE + int'(cmd[2:0])] = 1'b1;
        end else if (cmd[7:3] == CMD_CLRB) begin
          mm_d[MM_CMD_BASE + int'(cmd[2:0])] = 1'b0;
        end
      end
    end
    // Bus drive: status is resampled every cycle while the strobe is low
    oe_lo_d = reading;
    oe_hi_d = reading && bus16;
    if (rd_stat) begin
      o_data_d = stat;
    end else if (!reading) begin
      o_data_d = REG_RST;
    end else if (bus16) begin
      o_data_d = pf_q;
    end else begin
      o_data_d = {{B{1'b0}}, bp_q ? pf_q[B-1:0] : pf_q[W-1:B]};
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      load_q    <= '{default: REG_RST};
      hold_q    <= '{default: REG_RST};
      mode_q    <= '{default: REG_RST};
      alarm_q   <= '{default: REG_RST};
      mm_q      <= REG_RST;
      pf_q      <= REG_RST;
      o_data_q  <= REG_RST;
      grp_q     <= G_FIRST;
      elem_q    <= E_MODE;
      bp_q      <= 1'b1;
      pf_pend_q <= 1'b1;
      oe_lo_q   <= 1'b0;
      oe_hi_q   <= 1'b0;
    end else if (i_ce) begin
      load_q    <= load_d;
      hold_q    <= hold_d;
      mode_q    <= mode_d;
      alarm_q   <= alarm_d;
      mm_q      <= mm_d;
      pf_q      <= pf_d;
      o_data_q  <= o_data_d;
      grp_q     <= grp_d;
      elem_q    <= elem_d;
      bp_q      <= bp_d;
      pf_pend_q <= pf_pend_d;
      oe_lo_q   <= oe_lo_d;
      oe_hi_q   <= oe_hi_d;
    end
  end

  assign o_data       = o_data_q;
  assign o_data_oe_lo = oe_lo_q;
  assign o_data_oe_hi = oe_hi_q;
  assign o_out        = out_vec;

  // ----------------------------------------------------------------
  // Counter groups
  // ----------------------------------------------------------------
  tcg_grp_if gif [NG] ();

  for (genvar i = 0; i < NG; i++) begin : g_grp
    assign gif[i].load = load_q[i];
    assign gif[i].hold = hold_q[i];
    assign gif[i].mode = mode_q[i];
    assign gif[i].tick = ticks[i];
    assign cnt_vec[i]  = gif[i].cnt;
    assign out_vec[i]  = gif[i].out;
    if (i < NA) begin : g_alm
      assign gif[i].alarm  = alarm_q[i];
      assign gif[i].cmp_en = mm_q[MM_CMP1 + i];
    end else begin : g_noalm
      assign gif[i].alarm  = REG_RST;
      assign gif[i].cmp_en = 1'b0;
    end
    tcg_counter #(
      .W_CNT     (W),
      .HAS_ALARM (i < NA)
    ) u_cnt (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_ce     (i_ce),
      .g        (gif[i])
    );
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  ldp_sets_bp_a: assert property (i_ce && cmd_wr && cmd[7:5] == CMD_LDP
    |=> bp_q && grp_q == $past(cmd[2:0]) && pf_pend_q)
    else $error("pointer load did not set byte pointer");
  cs_idle_a: assert property (i_ce && f_q[F_CS] |=> !o_data_oe_lo && !o_data_oe_hi)
    else $error("bus driven without chip select");
  cs_nowr_a: assert property (i_ce && fp_q[F_CS] |=> $stable(mm_q) && $stable(bp_q))
    else $error("state changed without chip select");
  stat_live_a: assert property (i_ce && rd_stat |=> o_data == $past(stat))
    else $error("status read not live");
  seq_off_a: assert property (i_ce && mm_q[MM_SEQDIS] && acc
    |=> $stable(grp_q) && $stable(elem_q))
    else $error("pointer moved with sequencing disabled");
  bp16_a: assert property (i_ce && mm_q[MM_BUS16] && acc |=> bp_q)
    else $error("byte pointer cleared in 16-bit mode");
  bp8_a: assert property (i_ce && !mm_q[MM_BUS16] && acc |=> bp_q != $past(bp_q))
    else $error("byte pointer did not toggle");
  elem_wrap_a: assert property (i_ce && acc && full && !mm_q[MM_SEQDIS] && grp_ok
    && elem_q == E_HOLD |=> elem_q == E_MODE && grp_q == $past(gnext))
    else $error("element cycle wrap wrong");
  wr_once_a: assert property (i_ce && wr_edge |=> !wr_edge)
    else $error("write acted on twice");
  prefetch_a: assert property (i_ce && pf_pend_q |=> pf_q == $past(rdv))
    else $error("prefetch latch not loaded");
endmodule // tcg_host_access
`default_nettype wire

/* File: tcg_host_model.sv */
// Host processor model driving the asynchronous register pins.
// Assumes the bench resolves the data lines from both drivers.
`timescale 1ns/100ps
`default_nettype none
module tcg_host_model
  import tcg_pkg::*;
(
  input  wire logic         i_clk,
  input  wire logic [W-1:0] i_bus,
  output logic              o_cs_n,
  output logic              o_cd,
  output logic              o_rd_n,
  output logic              o_wr_n,
  output logic      [W-1:0] o_drv
);
  initial begin
    o_cs_n = 1'b1;
    o_cd   = 1'b0;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_drv  = 16'h0000;
  end

  // Select and data settle six clocks before the strobe falls
  task automatic open_xfer(input logic cs_n, input logic cd, input logic rd,
                           input logic [W-1:0] d);
    @(posedge i_clk);
    o_cs_n <= cs_n;
    o_cd   <= cd;
    if (!rd) begin
      o_drv <= d;
    end
    repeat (6) @(posedge i_clk);
    if (rd) begin
      o_rd_n <= 1'b0;
    end else begin
      o_wr_n <= 1'b0;
    end
    repeat (8) @(posedge i_clk);
  endtask

  // Chip select stays low afterwards, so accesses run back to back
  task automatic close_xfer(output logic [W-1:0] q);
    q = i_bus;
    o_rd_n <= 1'b1;
    o_wr_n <= 1'b1;
    repeat (6) @(posedge i_clk);
    // Released lines no longer show the last value
    o_drv <= ~o_drv;
  endtask
endmodule // tcg_host_model
`default_nettype wire

/* File: timer_counter_group_host_access_tb.sv */
// Self-checking bench for the counter group host access block.
// Assumes the host model file and the design files are compiled first.
`timescale 1ns/100ps
`default_nettype none
module timer_counter_group_host_access_tb;
  import tcg_pkg::*;
  logic          i_clk     = 1'b0;
  logic          i_resetn  = 1'b0;
  logic          ce        = 1'b1;
  logic [NG-1:0] count_src = 5'h00;
  logic          cs_n, cd, rd_n, wr_n, oe_lo, oe_hi;
  logic [NG-1:0] o_out;
  wire  [W-1:0]  drv, o_data, bus;
  logic [31:0]   seed      = 32'h6b04;
  logic          bus16     = 1'b0;
  logic [W-1:0]  q, w, a2;
  logic [W-1:0]  v [16];
  int            error_cnt = 0;
  int            checks    = 0;
  int            n;

  always #5 i_clk = ~i_clk;

  assign bus = {oe_hi ? o_data[15:8] : drv[15:8], oe_lo ? o_data[7:0] : drv[7:0]};

  tcg_host_model host (.i_clk(i_clk), .i_bus(bus), .o_cs_n(cs_n), .o_cd(cd),
                       .o_rd_n(rd_n), .o_wr_n(wr_n), .o_drv(drv));

  tcg_host_access DUT (.i_clk(i_clk), .i_resetn(i_resetn), .i_ce(ce), .i_cs_n(cs_n),
                       .i_cd(cd), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_data(bus),
                       .i_count_src(count_src), .o_data(o_data), .o_data_oe_lo(oe_lo),
                       .o_data_oe_hi(oe_hi), .o_out(o_out));

  // ----------------------------------------------------------------
  // Expectations and checks
  // ----------------------------------------------------------------
  function automatic logic [W-1:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction

  function automatic logic [W-1:0] st_exp(input logic [NG-1:0] o, input logic bp);
    return {10'h000, o, bp};
  endfunction

  function automatic logic [W-1:0] saved(input int k);
    return 16'h0000 - k[15:0];
  endfunction

  task automatic chk_word(input logic [W-1:0] got, input logic [W-1:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic give_verdict();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  task automatic xfer(input logic c_d, input logic rd, input logic [W-1:0] d);
    host.open_xfer(1'b0, c_d, rd, d);
    host.close_xfer(q);
  endtask

  task automatic cmd(input logic [7:0] c);
    xfer(1'b1, 1'b0, {8'hff, c});
  endtask

  task automatic wr16(input logic [W-1:0] d);
    if (bus16) begin
      xfer(1'b0, 1'b0, d);
    end else begin
      xfer(1'b0, 1'b0, {8'hff, d[7:0]});
      xfer(1'b0, 1'b0, {8'hff, d[15:8]});
    end
  endtask

  task automatic rd_chk(input logic [W-1:0] exp);
    logic [W-1:0] r;
    r = 16'h0000;
    for (int b = 0; b < (bus16 ? 1 : 2); b++) begin
      host.open_xfer(1'b0, 1'b0, 1'b1, 16'h0000);
      chk_bit(oe_lo, 1'b1);
      chk_bit(oe_hi, bus16);
      host.close_xfer(q);
      r = bus16 ? q : ((b == 0) ? {8'h00, q[7:0]} : {q[7:0], r[7:0]});
    end
    chk_word(r, exp);
  endtask

  task automatic status(input logic [W-1:0] exp);
    xfer(1'b1, 1'b1, 16'h0000);
    chk_word({8'h00, q[7:0]}, exp);
  endtask

  task automatic tick(input int g);
    @(posedge i_clk);
    count_src[g] <= 1'b1;
    repeat (6) @(posedge i_clk);
    count_src[g] <= 1'b0;
    repeat (6) @(posedge i_clk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    #300us;
    error_cnt++;
    give_verdict();
  end

  initial begin
    repeat (8) @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (2) @(posedge i_clk);
    chk_bit(oe_lo, 1'b0);
    chk_word({11'h000, o_out}, 16'h0000);
    status(st_exp(5'h00, 1'b1));
    // Element cycle over all five groups, then wrap into group one
    cmd(8'h01);
    for (int i = 0; i < 16; i++) begin
      v[i] = rnd();
      if (i == 0) begin
        xfer(1'b0, 1'b0, {8'hff, v[0][7:0]});
        status(st_exp({4'h0, v[0][2]}, 1'b0));
        xfer(1'b0, 1'b0, {8'hff, v[0][15:8]});
      end else begin
        wr16(v[i]);
      end
    end
    cmd(8'h01);
    for (int i = 0; i < 15; i++) begin
      rd_chk((i == 0) ? v[15] : v[i]);
    end
    // Control cycle over both alarm registers
    a2 = rnd();
    cmd(8'h07);
    wr16(16'hfffe);
    wr16(a2);
    cmd(8'h07);
    rd_chk(16'hfffe);
    rd_chk(a2);
    // Strobes with chip select high
    cmd(8'h09);
    host.open_xfer(1'b1, 1'b0, 1'b1, 16'h0000);
    chk_bit(oe_lo, 1'b0);
    host.close_xfer(q);
    host.open_xfer(1'b1, 1'b0, 1'b0, rnd());
    host.close_xfer(q);
    rd_chk(v[1]);
    // Wide bus
    cmd(8'hed);
    bus16 = 1'b1;
    w = rnd();
    cmd(8'h0b);
    wr16(w);
    status(st_exp({v[12][2], v[9][2], v[6][2], v[3][2], v[15][2]}, 1'b1));
    cmd(8'h0b);
    rd_chk(w);
    // Sequencing switched off by command
    cmd(8'hee);
    cmd(8'h0c);
    wr16(w);
    w = rnd();
    wr16(w);
    rd_chk(w);
    rd_chk(w);
    cmd(8'he6);
    // Save the live count of group three
    n = int'(w[2:0]) + 1;
    repeat (n) tick(2);
    cmd(8'ha4);
    cmd(8'h13);
    rd_chk(saved(n));
    // Comparator one on, comparator two off
    cmd(8'h17);
    wr16(16'h2004);
    cmd(8'h01);
    wr16(16'h0000);
    tick(0);
    tick(0);
    repeat (4) @(posedge i_clk);
    chk_bit(o_out[0], 1'b1);
    chk_bit(o_out[1], v[3][2]);
    host.open_xfer(1'b0, 1'b1, 1'b1, 16'h0000);
    chk_bit(bus[1], 1'b1);
    tick(0);
    repeat (4) @(posedge i_clk);
    chk_bit(bus[1], 1'b0);
    host.close_xfer(q);
    cmd(8'h01);
    wr16(16'h0004);
    repeat (4) @(posedge i_clk);
    chk_bit(o_out[0], 1'b1);
    // Clock enable low: a count pulse in that time is lost
    ce <= 1'b0;
    tick(0);
    chk_bit(o_out[0], 1'b1);
    ce <= 1'b1;
    cmd(8'ha1);
    cmd(8'h11);
    rd_chk(16'hfffd);
    give_verdict();
  end
endmodule // timer_counter_group_host_access_tb
`default_nettype wire
